// [common/dcss_pkg.sv]
// Purpose: constants and types for the dual channel start-up sequencer
// Assumes: 20 MHz ref_clk, analog comparisons arrive as digital levels
// Notes:   times in ns, cycle counts derived from the clock period
package dcss_pkg;

  localparam int unsigned CLK_PERIOD_NS   = 50;
  // fast comparator response, 1 us
  localparam int unsigned FAST_TRIP_NS    = 1000;
  localparam int unsigned FAST_TRIP_CYC   =
    (FAST_TRIP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // slow comparator default response, 15 us
  localparam int unsigned SLOW_TRIP_NS    = 15000;
  localparam int unsigned SLOW_TRIP_CYC   =
    (SLOW_TRIP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // enable held low to clear the fault latch, 15 us
  localparam int unsigned FLT_CLR_NS      = 15000;
  localparam int unsigned FLT_CLR_CYC     =
    (FLT_CLR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CNT_W           = 10;

  // foldback limit: 9 mV at 0 V, 25 mV at 0.5 V and above
  localparam logic [7:0]  ACL_MIN_MV      = 8'h09;
  localparam logic [7:0]  ACL_MAX_MV      = 8'h19;
  localparam logic [9:0]  FB_SAT_MV       = 10'h1F4;

  // gate drive current code: 9.5 uA in 0.5 uA steps
  localparam logic [4:0]  GATE_FULL_CODE  = 5'h13;
  localparam logic [4:0]  GATE_ZERO_CODE  = 5'h00;

  typedef enum logic [1:0] {
    DCSS_TMR_OFF,
    DCSS_TMR_PULL_DOWN,
    DCSS_TMR_UP_SMALL,
    DCSS_TMR_UP_LARGE
  } dcss_tmr_t;

  typedef enum logic [2:0] {
    DCSS_RESET,
    DCSS_CHECK,
    DCSS_INITIAL,
    DCSS_INIT_DISCH,
    DCSS_STARTUP,
    DCSS_RUN,
    DCSS_FAULT
  } dcss_state_t;

endpackage

// [core/dcss_sync.sv]
// Purpose: two flip-flop synchroniser for a bundle of comparator levels
// Assumes: inputs asynchronous to ref_clk
// Notes:   first stage feeds only the second stage
`timescale 1ns/10ps
`default_nettype none
module dcss_sync
  import dcss_pkg::*;
#(
  parameter int unsigned WIDTH = 8
)
(
  input  wire logic             ref_clk,
  input  wire logic             srst,
  input  wire logic [WIDTH-1:0] async_in,
  output var  logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_r;

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      meta_r   <= '0;
      sync_out <= '0;
    end
    else
    begin
      meta_r   <= async_in;
      sync_out <= meta_r;
    end
  end

endmodule
`default_nettype wire

// [core/dcss_top.sv]
// Purpose: start-up sequencer for a two-channel live-insertion switch
// Assumes: analog comparator results arrive as asynchronous levels
// Notes:   gate drive is a current code, foldback limit a mV value
//
// Summary of operation
// RL1: primary enable low holds reset, gates and timing node pulled low; the code keeps a latched fault instead of reset.
// RL2: initial cycle needs supplies ok, an enable high, gates and timer low.
// RL3: initial cycle charges timing node with the small 1.9 uA pull-up.
// RL4: timing node at high threshold is discharged, ending initial cycle.
// RL5: start-up only if filter below 1.24 V and fault line high.
// RL6: start-up charges timing node with 20 uA from low to high threshold.
// RL7: start-up arms breaker and enables 9.5 uA gate source per channel.
// RL8: limit folds back: 9 mV at 0 V feedback, 25 mV from 0.5 V.
// RL9: inrush above limit cuts gate current; full current back when it falls.
// RL10: end of start-up disengages servo and arms slow comparator.
// RL11: fast comparators armed after initial cycle; 100 mV over 1 us trips.
// RL12: trip latches fault, grounds gates; enable low 15 us clears it.
// RL13: armed slow comparator trips after 25 mV for over 15 us or filter.
// RL14: comparator levels are synchronised; states advance on clock edges.
`timescale 1ns/10ps
`default_nettype none
module dcss_top
  import dcss_pkg::*;
#(
  parameter int unsigned FAST_CYC  = FAST_TRIP_CYC,
  parameter int unsigned SLOW_CYC  = SLOW_TRIP_CYC,
  parameter int unsigned CLR_CYC   = FLT_CLR_CYC
)
(
  input  wire logic       ref_clk,
  input  wire logic       srst,
  input  wire logic       primary_channel_enable,
  input  wire logic       secondary_enable_high,
  input  wire logic       enable_above_reset,
  input  wire logic [1:0] supply_above_undervoltage_lockout,
  input  wire logic [1:0] gate_below_low,
  input  wire logic       timer_below_low,
  input  wire logic       timer_at_high,
  input  wire logic       filter_below_trip,
  input  wire logic       fault_line_high,
  input  wire logic       slow_filter_tripped,
  input  wire logic [1:0] sense_above_fast,
  input  wire logic [1:0] sense_above_slow,
  input  wire logic [1:0] inrush_above_limit,
  input  wire logic [9:0] output_feedback_ch0_mv,
  input  wire logic [9:0] output_feedback_ch1_mv,
  output var  logic [1:0] timer_drive_sel,
  output var  logic [4:0] gate_current_ch0,
  output var  logic [4:0] gate_current_ch1,
  output var  logic [7:0] active_limit_threshold_ch0,
  output var  logic [7:0] active_limit_threshold_ch1,
  output var  logic       breaker_armed,
  output var  logic [1:0] fast_armed,
  output var  logic [1:0] slow_armed,
  output var  logic       fault_pull_low,
  output var  logic       in_reset
);

  ////////////////////////////////////////////////////////////////////////////
  // synchronised comparator levels

  localparam int unsigned SW = 17;

  logic [SW-1:0] raw_w;
  logic [SW-1:0] syn_w;

  assign raw_w = {primary_channel_enable, secondary_enable_high,
                  enable_above_reset, supply_above_undervoltage_lockout, gate_below_low,
                  timer_below_low, timer_at_high, filter_below_trip,
                  fault_line_high, slow_filter_tripped, sense_above_fast,
                  sense_above_slow[0], inrush_above_limit[0],
                  sense_above_slow[1]};

  dcss_sync #(
    .WIDTH    (SW)
  ) dcss_sync_i (
    .ref_clk  (ref_clk),
    .srst     (srst),
    .async_in (raw_w),
    .sync_out (syn_w)
  ); // RL14

  logic       en1_s;
  logic       en2_s;
  logic       en_rst_s;
  logic [1:0] undervoltage_lockout_s;
  logic [1:0] gate_lo_s;
  logic       tmr_lo_s;
  logic       tmr_hi_s;
  logic       filt_lo_s;
  logic       fault_hi_s;
  logic       filt_trip_s;
  logic [1:0] fast_s;
  logic [1:0] slow_s;
  logic       inr0_s;

  assign {en1_s, en2_s, en_rst_s, undervoltage_lockout_s, gate_lo_s, tmr_lo_s, tmr_hi_s,
          filt_lo_s, fault_hi_s, filt_trip_s, fast_s, slow_s[0], inr0_s,
          slow_s[1]} = syn_w;

  // second channel inrush flag synchronised on its own
  logic inr1_m_r;
  logic inr1_s;

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      inr1_m_r <= 1'b0;
      inr1_s   <= 1'b0;
    end
    else
    begin
      inr1_m_r <= inrush_above_limit[1];
      inr1_s   <= inr1_m_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // foldback limit

  function automatic logic [7:0] fold_limit(input logic [9:0] fb_mv);
    logic [13:0] scaled;
    scaled = 14'h0000;
    if (fb_mv >= FB_SAT_MV)
      fold_limit = ACL_MAX_MV;
    else
    begin
      // 16 mV over 500 mV of feedback
      scaled = 14'(fb_mv) * 14'h0010 / 14'(FB_SAT_MV);
      fold_limit = ACL_MIN_MV + 8'(scaled);
    end
  endfunction

  logic [7:0] acl0_w;
  logic [7:0] acl1_w;

  assign acl0_w = fold_limit(output_feedback_ch0_mv); // RL8
  assign acl1_w = fold_limit(output_feedback_ch1_mv); // RL8

  ////////////////////////////////////////////////////////////////////////////
  // sequencer

  dcss_state_t        state_r;
  dcss_state_t        state_nxt;
  logic [CNT_W-1:0]   clr_cnt_r;
  logic [CNT_W-1:0]   fast_cnt0_r;
  logic [CNT_W-1:0]   fast_cnt1_r;
  logic [CNT_W-1:0]   slow_cnt0_r;
  logic [CNT_W-1:0]   slow_cnt1_r;

  logic eligible_w;
  logic may_start_w;
  logic fast_trip_w;
  logic slow_trip_w;
  logic trip_w;
  logic clr_done_w;

  assign eligible_w  = &undervoltage_lockout_s && (en1_s || en2_s) && &gate_lo_s
                       && tmr_lo_s; // RL2
  assign may_start_w = filt_lo_s && fault_hi_s; // RL5
  assign fast_trip_w = (fast_cnt0_r >= CNT_W'(FAST_CYC))
                       || (fast_cnt1_r >= CNT_W'(FAST_CYC)); // RL11
  assign slow_trip_w = (slow_cnt0_r >= CNT_W'(SLOW_CYC))
                       || (slow_cnt1_r >= CNT_W'(SLOW_CYC))
                       || (filt_trip_s && |slow_armed); // RL13
  assign trip_w      = fast_trip_w || slow_trip_w;
  assign clr_done_w  = clr_cnt_r >= CNT_W'(CLR_CYC);

  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      DCSS_RESET:
        if (en1_s)
          state_nxt = DCSS_CHECK;
      DCSS_CHECK:
        if (eligible_w)
          state_nxt = DCSS_INITIAL; // RL3
      DCSS_INITIAL:
        if (tmr_hi_s)
          state_nxt = DCSS_INIT_DISCH; // RL4
      DCSS_INIT_DISCH:
        if (tmr_lo_s && may_start_w)
          state_nxt = DCSS_STARTUP; // RL5
      DCSS_STARTUP:
        if (trip_w)
          state_nxt = DCSS_FAULT;
        else if (tmr_hi_s)
          state_nxt = DCSS_RUN; // RL10
      DCSS_RUN:
        if (trip_w)
          state_nxt = DCSS_FAULT;
      DCSS_FAULT:
        if (clr_done_w)
          state_nxt = DCSS_RESET; // RL12
      default:
        state_nxt = DCSS_RESET;
    endcase
    if (!en1_s && state_r != DCSS_FAULT)
      state_nxt = DCSS_RESET; // RL1
    if (trip_w && state_r == DCSS_INIT_DISCH)
      state_nxt = DCSS_FAULT; // RL11
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
      state_r <= DCSS_RESET;
    else
      state_r <= state_nxt;
  end

  // fault latch clear: enable held below reset level
  always_ff @(posedge ref_clk)
  begin
    if (srst || state_r != DCSS_FAULT || en_rst_s)
      clr_cnt_r <= '0;
    else if (!clr_done_w)
      clr_cnt_r <= clr_cnt_r + 1'b1; // RL12
  end

  ////////////////////////////////////////////////////////////////////////////
  // overcurrent filters

  logic fast_arm_w;

  assign fast_arm_w = (state_r == DCSS_INIT_DISCH && tmr_lo_s)
                      || (state_r == DCSS_STARTUP)
                      || (state_r == DCSS_RUN); // RL11

  always_ff @(posedge ref_clk)
  begin
    if (srst || !fast_arm_w || !fast_s[0])
      fast_cnt0_r <= '0;
    else if (!fast_trip_w)
      fast_cnt0_r <= fast_cnt0_r + 1'b1; // RL11
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst || !fast_arm_w || !fast_s[1])
      fast_cnt1_r <= '0;
    else if (!fast_trip_w)
      fast_cnt1_r <= fast_cnt1_r + 1'b1; // RL11
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst || !slow_armed[0] || !slow_s[0])
      slow_cnt0_r <= '0;
    else if (!slow_trip_w)
      slow_cnt0_r <= slow_cnt0_r + 1'b1; // RL13
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst || !slow_armed[1] || !slow_s[1])
      slow_cnt1_r <= '0;
    else if (!slow_trip_w)
      slow_cnt1_r <= slow_cnt1_r + 1'b1; // RL13
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  logic [1:0] tmr_nxt;
  logic [4:0] g0_nxt;
  logic [4:0] g1_nxt;
  logic       st_w;

  assign st_w    = (state_nxt == DCSS_STARTUP) || (state_nxt == DCSS_RUN);
  assign tmr_nxt = (state_nxt == DCSS_INITIAL) ? 2'(DCSS_TMR_UP_SMALL) // RL3
                 : (state_nxt == DCSS_STARTUP) ? 2'(DCSS_TMR_UP_LARGE) // RL6
                 : (state_nxt == DCSS_CHECK)   ? 2'(DCSS_TMR_OFF)
                 : 2'(DCSS_TMR_PULL_DOWN); // RL1 RL4
  assign g0_nxt  = !st_w ? GATE_ZERO_CODE // RL1 RL12
                 : (state_nxt == DCSS_STARTUP && inr0_s) ? GATE_FULL_CODE
                   - 5'h0A : GATE_FULL_CODE; // RL7 RL9
  assign g1_nxt  = !st_w ? GATE_ZERO_CODE // RL1 RL12
                 : (state_nxt == DCSS_STARTUP && inr1_s) ? GATE_FULL_CODE
                   - 5'h0A : GATE_FULL_CODE; // RL7 RL9

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      timer_drive_sel            <= 2'(DCSS_TMR_PULL_DOWN);
      gate_current_ch0           <= GATE_ZERO_CODE;
      gate_current_ch1           <= GATE_ZERO_CODE;
      active_limit_threshold_ch0 <= ACL_MIN_MV;
      active_limit_threshold_ch1 <= ACL_MIN_MV;
      breaker_armed              <= 1'b0;
      fast_armed                 <= 2'h0;
      slow_armed                 <= 2'h0;
      fault_pull_low             <= 1'b0;
      in_reset                   <= 1'b1;
    end
    else
    begin
      timer_drive_sel            <= tmr_nxt;
      gate_current_ch0           <= g0_nxt;
      gate_current_ch1           <= g1_nxt;
      active_limit_threshold_ch0 <= acl0_w;
      active_limit_threshold_ch1 <= acl1_w;
      breaker_armed              <= st_w; // RL7
      fast_armed                 <= {2{fast_arm_w && !trip_w}}; // RL11
      slow_armed                 <= {2{state_nxt == DCSS_RUN}}; // RL10
      fault_pull_low             <= state_nxt == DCSS_FAULT; // RL12
      in_reset                   <= state_nxt == DCSS_RESET; // RL1
    end
  end

endmodule
`default_nettype wire

// [sim/dcss_props.sv]
// Purpose: port checker for the start-up sequencer
// Assumes: trip and clear counts follow the bound design
// Notes:   bound to dcss_top
`timescale 1ns/10ps
`default_nettype none
module dcss_props
  import dcss_pkg::*;
#(
  parameter int unsigned FAST_CYC = FAST_TRIP_CYC,
  parameter int unsigned SLOW_CYC = SLOW_TRIP_CYC,
  parameter int unsigned CLR_CYC  = FLT_CLR_CYC
)
(
  input wire logic       ref_clk,
  input wire logic       srst,
  input wire logic       primary_channel_enable,
  input wire logic       enable_above_reset,
  input wire logic [1:0] sense_above_fast,
  input wire logic [1:0] sense_above_slow,
  input wire logic [1:0] inrush_above_limit,
  input wire logic [9:0] output_feedback_ch0_mv,
  input wire logic [1:0] timer_drive_sel,
  input wire logic [4:0] gate_current_ch0,
  input wire logic [4:0] gate_current_ch1,
  input wire logic [7:0] active_limit_threshold_ch0,
  input wire logic       breaker_armed,
  input wire logic [1:0] fast_armed,
  input wire logic [1:0] slow_armed,
  input wire logic       fault_pull_low,
  input wire logic       in_reset
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (srst);

  ////////////////////////////////////////////////////////////////////////////
  // consecutive sampled cycles of the channel 1 fast trip, channel 0 slow trip and clear conditions
  int unsigned fast_run_r;
  int unsigned slow_run_r;
  int unsigned clr_run_r;

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      fast_run_r <= 0;
      slow_run_r <= 0;
      clr_run_r  <= 0;
    end
    else
    begin
      fast_run_r <= (fast_armed[1] && sense_above_fast[1])
                    ? fast_run_r + 1 : 0;
      slow_run_r <= (slow_armed[0] && sense_above_slow[0])
                    ? slow_run_r + 1 : 0;
      clr_run_r  <= !enable_above_reset ? clr_run_r + 1 : 0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // count plus two synchroniser stages and the output flop
  sequence fast_over;
    fast_run_r == FAST_CYC + 3;
  endsequence
  sequence slow_over;
    slow_run_r == SLOW_CYC + 3;
  endsequence
  sequence clr_low;
    clr_run_r == CLR_CYC + 3;
  endsequence

  ////////////////////////////////////////////////////////////////////////////
  reset_hold_a: assert property (in_reset |-> gate_current_ch0 == 5'h00
    && timer_drive_sel == DCSS_TMR_PULL_DOWN) else $error("reset not held");
  enable_low_a: assert property (
    (!primary_channel_enable && !fault_pull_low) [*4] |=> in_reset)
    else $error("enable low ignored");
  init_charge_a: assert property (timer_drive_sel == DCSS_TMR_UP_SMALL
    |-> !breaker_armed && gate_current_ch0 == 5'h00) else $error("early gate");
  startup_arm_a: assert property (
    timer_drive_sel == DCSS_TMR_UP_LARGE |-> breaker_armed
    && fast_armed == 2'h3 && slow_armed == 2'h0) else $error("arming wrong");
  servo_cut_a: assert property (
    (inrush_above_limit[0] && timer_drive_sel == DCSS_TMR_UP_LARGE) [*4]
    |-> gate_current_ch0 == 5'h09) else $error("servo not cutting");
  run_full_a: assert property (slow_armed[0] && !fault_pull_low
    |-> gate_current_ch0 == GATE_FULL_CODE) else $error("servo still on");
  fold_max_a: assert property ($past(output_feedback_ch0_mv) >= FB_SAT_MV
    |-> active_limit_threshold_ch0 == ACL_MAX_MV) else $error("no saturation");
  fast_trip_a: assert property (fast_over |-> fault_pull_low)
    else $error("fast comparator missed");
  slow_trip_a: assert property (slow_over |-> fault_pull_low)
    else $error("slow comparator missed");
  fault_gates_a: assert property (fault_pull_low |-> !breaker_armed
    && gate_current_ch0 == 5'h00 && gate_current_ch1 == 5'h00)
    else $error("gates not grounded");
  fault_clear_a: assert property (clr_low |-> !fault_pull_low)
    else $error("fault not cleared");
endmodule
bind dcss_top dcss_props #(.FAST_CYC(FAST_CYC), .SLOW_CYC(SLOW_CYC),
  .CLR_CYC(CLR_CYC)) dcss_props_i (.ref_clk(ref_clk), .srst(srst),
  .primary_channel_enable(primary_channel_enable),
  .enable_above_reset(enable_above_reset), .fast_armed(fast_armed),
  .sense_above_fast(sense_above_fast), .sense_above_slow(sense_above_slow),
  .inrush_above_limit(inrush_above_limit), .slow_armed(slow_armed),
  .output_feedback_ch0_mv(output_feedback_ch0_mv), .in_reset(in_reset),
  .timer_drive_sel(timer_drive_sel), .gate_current_ch0(gate_current_ch0),
  .gate_current_ch1(gate_current_ch1), .breaker_armed(breaker_armed),
  .active_limit_threshold_ch0(active_limit_threshold_ch0),
  .fault_pull_low(fault_pull_low));
`default_nettype wire

// [sim/test_dual_channel_startup_sequencer.sv]
// Purpose: directed bench for the start-up sequencer
// Assumes: inputs change at the falling edge
// Notes:   counts shortened to 2, 4, 4
`timescale 1ns/10ps
`default_nettype none
module test_dual_channel_startup_sequencer
  import dcss_pkg::*;
;
  logic       ref_clk, srst, primary_channel_enable, enable_above_reset;
  logic       timer_below_low, timer_at_high, filter_below_trip;
  logic       breaker_armed, fault_pull_low, in_reset;
  logic [1:0] supply_above_undervoltage_lockout, sense_above_fast, sense_above_slow;
  logic [1:0] inrush_above_limit, timer_drive_sel, fast_armed, slow_armed;
  logic       fault_line_high;
  logic [1:0] gate_below_low;
  logic [9:0] output_feedback_ch0_mv, output_feedback_ch1_mv;
  logic [4:0] gate_current_ch0, gate_current_ch1;
  logic [7:0] active_limit_threshold_ch0, active_limit_threshold_ch1;
  int         error_cnt, comparisons;

  dcss_top #(.FAST_CYC(2), .SLOW_CYC(4), .CLR_CYC(4)) dcss_top_i (
    .ref_clk(ref_clk), .srst(srst), .secondary_enable_high(1'b0),
    .primary_channel_enable(primary_channel_enable),
    .enable_above_reset(enable_above_reset),
    .gate_below_low(gate_below_low),
    .supply_above_undervoltage_lockout(supply_above_undervoltage_lockout), .timer_below_low(timer_below_low),
    .timer_at_high(timer_at_high), .filter_below_trip(filter_below_trip),
    .fault_line_high(fault_line_high), .slow_filter_tripped(1'b0),
    .sense_above_fast(sense_above_fast), .sense_above_slow(sense_above_slow),
    .inrush_above_limit(inrush_above_limit),
    .output_feedback_ch1_mv(output_feedback_ch1_mv),
    .output_feedback_ch0_mv(output_feedback_ch0_mv),
    .timer_drive_sel(timer_drive_sel), .gate_current_ch0(gate_current_ch0),
    .gate_current_ch1(gate_current_ch1),
    .active_limit_threshold_ch1(active_limit_threshold_ch1),
    .active_limit_threshold_ch0(active_limit_threshold_ch0),
    .breaker_armed(breaker_armed), .fast_armed(fast_armed),
    .slow_armed(slow_armed), .fault_pull_low(fault_pull_low),
    .in_reset(in_reset));

  always #25 ref_clk = ~ref_clk;

  ////////////////////////////////////////////////////////////////////////////
  task chk(input logic [15:0] s, input logic [15:0] e);
    comparisons++;
    if (s !== e)
    begin
      error_cnt++;
      $display("Error at %0t: seen %h expected %h", $time, s, e);
    end
  endtask

  task finish_test;
    $display("%0d errors in %0d comparisons", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task wt(input int m, input logic [1:0] v);
    int n;
    n = 0;
    while ((m == 0 ? timer_drive_sel : (m == 1 ? {1'b0, fault_pull_low}
           : {1'b0, in_reset})) !== v && n < 40)
    begin
      @(negedge ref_clk);
      n++;
    end
    if (n == 40)
    begin
      chk(0, 1);
      finish_test;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task t_bring;
    primary_channel_enable = 1;
    supply_above_undervoltage_lockout = 2'h1;
    timer_below_low = 1;
    repeat (6) @(negedge ref_clk);
    chk(timer_drive_sel, DCSS_TMR_OFF);
    supply_above_undervoltage_lockout = 2'h3;
    gate_below_low = 2'h2;
    repeat (6) @(negedge ref_clk);
    chk(timer_drive_sel, DCSS_TMR_OFF);
    gate_below_low = 2'h3;
    wt(0, DCSS_TMR_UP_SMALL);
    timer_below_low = 0;
    timer_at_high = 1;
    filter_below_trip = 0;
    wt(0, DCSS_TMR_PULL_DOWN);
    timer_at_high = 0;
    timer_below_low = 1;
    repeat (6) @(negedge ref_clk);
    chk(timer_drive_sel, DCSS_TMR_PULL_DOWN);
    filter_below_trip = 1;
    fault_line_high = 0;
    repeat (6) @(negedge ref_clk);
    chk(timer_drive_sel, DCSS_TMR_PULL_DOWN);
    fault_line_high = 1;
    wt(0, DCSS_TMR_UP_LARGE);
    timer_below_low = 0;
    chk({breaker_armed, fast_armed, gate_current_ch1}, 10'h0F3);
    $display("start-up test done");
  endtask

  task t_limit;
    inrush_above_limit = 2'h1;
    repeat (4) @(negedge ref_clk);
    chk({gate_current_ch0, gate_current_ch1}, 10'h133);
    inrush_above_limit = 2'h0;
    output_feedback_ch0_mv = 10'h0FA;
    repeat (4) @(negedge ref_clk);
    chk(gate_current_ch0, GATE_FULL_CODE);
    chk(active_limit_threshold_ch0, 8'h11);
    output_feedback_ch0_mv = 10'h1F4;
    output_feedback_ch1_mv = 10'h1F4;
    @(negedge ref_clk);
    @(negedge ref_clk);
    chk(active_limit_threshold_ch0, ACL_MAX_MV);
    chk(active_limit_threshold_ch1, ACL_MAX_MV);
    timer_at_high = 1;
    repeat (4) @(negedge ref_clk);
    chk({slow_armed, gate_current_ch0}, 10'h073);
    timer_at_high = 0;
    $display("limit test done");
  endtask

  task t_trip(input logic fast);
    if (!fast)
    begin
      timer_at_high = 1;
      wt(0, DCSS_TMR_PULL_DOWN);
      timer_at_high = 0;
      chk(slow_armed, 2'h3);
    end
    if (fast)
      sense_above_fast = 2'h2;
    else
      sense_above_slow = 2'h1;
    wt(1, 2'h1);
    chk({gate_current_ch0, gate_current_ch1}, 10'h000);
    primary_channel_enable = 0;
    sense_above_fast = 2'h0;
    sense_above_slow = 2'h0;
    repeat (10) @(negedge ref_clk);
    chk(fault_pull_low, 1);
    enable_above_reset = 0;
    wt(2, 2'h1);
    chk(fault_pull_low, 0);
    enable_above_reset = 1;
    $display("trip test done");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    ref_clk = 0;
    srst = 1;
    primary_channel_enable = 0;
    enable_above_reset = 1;
    supply_above_undervoltage_lockout = 2'h3;
    timer_below_low = 1;
    timer_at_high = 0;
    filter_below_trip = 1;
    sense_above_fast = 2'h0;
    sense_above_slow = 2'h0;
    inrush_above_limit = 2'h0;
    output_feedback_ch0_mv = 10'h000;
    output_feedback_ch1_mv = 10'h000;
    gate_below_low = 2'h3;
    fault_line_high = 1;
    error_cnt = 0;
    comparisons = 0;
    repeat (4) @(negedge ref_clk);
    srst = 0;
    @(negedge ref_clk);
    chk({in_reset, timer_drive_sel, active_limit_threshold_ch0}, 16'h0509);
    chk(active_limit_threshold_ch1, ACL_MIN_MV);
    t_bring;
    t_limit;
    t_trip(1);
    t_bring;
    t_trip(0);
    finish_test;
  end
endmodule
`default_nettype wire
